// file: verilog/irf_cfg.svh
// Register offsets, field positions and reset values of the request/error block.
`ifndef IRF_CFG_SVH
`define IRF_CFG_SVH
`define IRF_ADDR_W        6
`define IRF_OFF_COMMAND   6'h01
`define IRF_OFF_COM_EN    6'h02
`define IRF_OFF_MISC_EN   6'h03
`define IRF_OFF_COM_REQ   6'h04
`define IRF_OFF_MISC_REQ  6'h05
`define IRF_OFF_ERR       6'h06
`define IRF_OFF_RX_MODE   6'h13
`define IRF_SET_SEL_BIT   7
`define IRF_COM_TX        6
`define IRF_COM_RX        5
`define IRF_COM_IDLE      4
`define IRF_COM_HI        3
`define IRF_COM_LO        2
`define IRF_COM_ERR       1
`define IRF_COM_TIMER     0
`define IRF_MISC_EXT      4
`define IRF_MISC_CRC      2
`define IRF_ERR_WR        7
`define IRF_ERR_TEMP      6
`define IRF_ERR_OVFL      4
`define IRF_ERR_COLL      3
`define IRF_ERR_CRC       2
`define IRF_ERR_PAR       1
`define IRF_ERR_PROT      0
`define IRF_COM_MASK      8'h7F
`define IRF_MISC_MASK     8'h14
`define IRF_MISC_EN_MASK  8'h94
`define IRF_ERR_MASK      8'hDF
`define IRF_ERR_KEEP      8'h40
`define IRF_COM_RST       8'h14
`define IRF_MISC_RST      8'h00
`define IRF_ERR_RST       8'h00
`define IRF_COM_EN_RST    8'h80
`define IRF_MISC_EN_RST   8'h00
`define IRF_RXMODE_RST    8'h00
`define IRF_RXMODE_CRCEN  7
`define IRF_RXMODE_NOERR  3
`define IRF_EN_INV_BIT    7
`endif

// file: verilog/irf_pkg.sv
// Types shared by the request/error block.
package irf_pkg;
  typedef enum logic [1:0] {
    IRF_CMD_IDLE   = 2'b00,
    IRF_CMD_RUN    = 2'b01,
    IRF_CMD_UNKNWN = 2'b10
  } irf_cmd_e;
  typedef logic [7:0] irf_byte_t;
endpackage

// file: verilog/irf_setclr.sv
// Set/clear-select request register with hardware event inputs.
`timescale 1ns/10ps
`include "irf_cfg.svh"
module irf_setclr (
  // Clock and reset
  input  wire logic       clk_sys_in,
  input  wire logic       sys_rst_in,
  input  wire logic       clk_en_in,
  // Configuration
  input  wire logic [7:0] reset_val_in,
  input  wire logic [7:0] valid_mask_in,
  // Software write
  input  wire logic       wr_in,
  input  wire logic [7:0] wdata_in,
  // Hardware events
  input  wire logic [7:0] event_in,
  // Flags
  output logic      [7:0] flags_out
);
  logic [7:0] flags_r;
  logic [7:0] flags_nxt;
  logic       rst_seen_r;
  logic       rst_seen_nxt;
  logic [7:0] sw_bits;

  always_comb begin
    sw_bits      = wdata_in & valid_mask_in;
    flags_nxt    = flags_r;
    rst_seen_nxt = 1'b1;
    if (!rst_seen_r) begin
      flags_nxt = reset_val_in & valid_mask_in;
    end else if (wr_in) begin
      if (wdata_in[`IRF_SET_SEL_BIT]) begin
        flags_nxt = flags_r | sw_bits;
      end else begin
        flags_nxt = flags_r & ~sw_bits;
      end
    end
    flags_nxt = flags_nxt | (event_in & valid_mask_in & {8{rst_seen_r}});
  end

  always_ff @(posedge clk_sys_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      flags_r    <= 8'h00;
      rst_seen_r <= 1'b0;
    end else if (clk_en_in) begin
      flags_r    <= flags_nxt;
      rst_seen_r <= rst_seen_nxt;
    end
  end

  assign flags_out = rst_seen_r ? flags_r : (reset_val_in & valid_mask_in);
endmodule

// file: verilog/irf_edge.sv
// Rising/falling edge detector for the external input and alert levels.
`timescale 1ns/10ps
module irf_edge (
  // Clock and reset
  input  wire logic       clk_sys_in,
  input  wire logic       sys_rst_in,
  input  wire logic       clk_en_in,
  // Levels
  input  wire logic [2:0] level_in,
  // Edges
  output logic      [2:0] rise_out,
  output logic      [2:0] fall_out
);
  logic [2:0] prev_r;
  logic [2:0] prev_nxt;
  logic       armed_r;
  logic       armed_nxt;

  always_comb begin
    prev_nxt  = level_in;
    armed_nxt = 1'b1;
  end

  always_ff @(posedge clk_sys_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      prev_r  <= 3'h0;
      armed_r <= 1'b0;
    end else if (clk_en_in) begin
      prev_r  <= prev_nxt;
      armed_r <= armed_nxt;
    end
  end

  assign rise_out = level_in & ~prev_r & {3{armed_r}};
  assign fall_out = ~level_in & prev_r & {3{armed_r}};
endmodule

// file: verilog/irf_top.sv
// Interrupt request latching and error flag block with register port.
`timescale 1ns/10ps
`include "irf_cfg.svh"
// Operation
// - Common request write: bit 7 high sets, low clears ones.
// - Miscellaneous request write uses the same set/clear scheme.
// - Transmit request set when the last frame bit is sent.
// - Receive request on valid end; with no-error option only if FIFO data.
// - Idle request when command ends or unknown command reverts to idle.
// - Host writing the idle command does not set the idle request.
// - High-alert request latches on status rising, held until cleared.
// - Low-alert request latches on status rising, held until cleared.
// - Error request set whenever any error flag is set.
// - Timer request set when timer decrements to zero.
// - External input request set on either input edge.
// - CRC-done request when checksum command active and data processed.
// - Write misuse flag on host FIFO write in authentication or rx gap.
// - Overheat sets overtemperature flag and switches antenna drivers off.
// - Overflow flag on any FIFO write while full.
// - Collision flag at 106 kBd only; cleared at receiver start.
// - Checksum fail flag when rx check enabled; cleared at receiver start.
// - Parity flag at 106 kBd type A; cleared at receiver start.
// - Frame-start flag at 106 kBd; cleared at receiver start.
// - Wrong byte count during authentication sets frame-start flag.
// - Command start clears errors except overtemperature; never software-set.
// - Common request resets to 14h, error flags to 00h.
// - Summary interrupt from enabled requests; invert selects pin polarity.
module irf_top (
  // Clock, reset, enable
  input  wire logic       clk_sys_in,
  input  wire logic       sys_rst_in,
  input  wire logic       clk_en_in,
  // Register port
  input  wire logic [5:0] reg_addr_in,
  input  wire logic [7:0] reg_wdata_in,
  input  wire logic       reg_wr_in,
  input  wire logic       reg_rd_in,
  output logic      [7:0] reg_rdata_out,
  // Command engine
  input  wire logic       cmd_done_in,
  input  wire logic       cmd_auth_active_in,
  input  wire logic       cmd_calc_active_in,
  input  wire logic       calc_all_processed_in,
  // Transmitter and receiver
  input  wire logic       tx_last_bit_sent_in,
  input  wire logic       rx_valid_end_in,
  input  wire logic       rx_start_in,
  input  wire logic       rx_gap_active_in,
  input  wire logic       rx_rate_106_in,
  input  wire logic       rx_type_a_in,
  input  wire logic       bit_collision_in,
  input  wire logic       rx_checksum_bad_in,
  input  wire logic       parity_bad_in,
  input  wire logic       frame_start_bad_in,
  input  wire logic       auth_byte_count_bad_in,
  // FIFO, timer, sensors
  input  wire logic       fifo_not_empty_in,
  input  wire logic       fifo_full_in,
  input  wire logic       fifo_host_wr_in,
  input  wire logic       fifo_int_wr_in,
  input  wire logic       fifo_high_status_in,
  input  wire logic       fifo_low_status_in,
  input  wire logic       timer_zero_in,
  input  wire logic       overheat_in,
  input  wire logic       contactless_ext_input_in,
  // Outputs
  output logic      [3:0] command_code_out,
  output logic            cmd_start_out,
  output logic            antenna_off_out,
  output logic            irq_summary_out,
  output logic            irq_pin_out
);
  // ----------------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------------
  function automatic logic hit(input logic [5:0] a, input logic [5:0] off);
    hit = (a == off);
  endfunction

  logic wr_cmd;
  logic wr_com_en;
  logic wr_misc_en;
  logic wr_com_req;
  logic wr_misc_req;
  logic wr_rx_mode;

  assign wr_cmd      = reg_wr_in & hit(reg_addr_in, `IRF_OFF_COMMAND);
  assign wr_com_en   = reg_wr_in & hit(reg_addr_in, `IRF_OFF_COM_EN);
  assign wr_misc_en  = reg_wr_in & hit(reg_addr_in, `IRF_OFF_MISC_EN);
  assign wr_com_req  = reg_wr_in & hit(reg_addr_in, `IRF_OFF_COM_REQ);
  assign wr_misc_req = reg_wr_in & hit(reg_addr_in, `IRF_OFF_MISC_REQ);
  assign wr_rx_mode  = reg_wr_in & hit(reg_addr_in, `IRF_OFF_RX_MODE);

  // ----------------------------------------------------------------------
  // Control registers and command tracking
  // ----------------------------------------------------------------------
  irf_pkg::irf_cmd_e cmd_st_r;
  irf_pkg::irf_cmd_e cmd_st_nxt;
  logic [3:0]        cmd_code_r;
  logic [3:0]        cmd_code_nxt;
  logic [7:0]        com_en_r;
  logic [7:0]        com_en_nxt;
  logic [7:0]        misc_en_r;
  logic [7:0]        misc_en_nxt;
  logic [7:0]        rx_mode_r;
  logic [7:0]        rx_mode_nxt;
  logic              idle_evt;
  logic              start_evt;

  function automatic logic known_cmd(input logic [3:0] c);
    case (c)
      4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h7, 4'h8, 4'hC, 4'hE, 4'hF:
        known_cmd = 1'b1;
      default:
        known_cmd = 1'b0;
    endcase
  endfunction

  always_comb begin
    cmd_st_nxt   = cmd_st_r;
    cmd_code_nxt = cmd_code_r;
    com_en_nxt   = com_en_r;
    misc_en_nxt  = misc_en_r;
    rx_mode_nxt  = rx_mode_r;
    idle_evt     = 1'b0;
    start_evt    = 1'b0;
    if (wr_com_en) begin
      com_en_nxt = reg_wdata_in;
    end
    if (wr_misc_en) begin
      misc_en_nxt = reg_wdata_in & `IRF_MISC_EN_MASK;
    end
    if (wr_rx_mode) begin
      rx_mode_nxt = reg_wdata_in;
    end
    case (cmd_st_r)
      irf_pkg::IRF_CMD_IDLE: begin
        if (wr_cmd && reg_wdata_in[3:0] != 4'h0) begin
          start_evt = 1'b1;
          if (known_cmd(reg_wdata_in[3:0])) begin
            cmd_code_nxt = reg_wdata_in[3:0];
            cmd_st_nxt   = irf_pkg::IRF_CMD_RUN;
          end else begin
            cmd_st_nxt   = irf_pkg::IRF_CMD_UNKNWN;
          end
        end
      end
      irf_pkg::IRF_CMD_RUN: begin
        if (wr_cmd && reg_wdata_in[3:0] == 4'h0) begin
          cmd_code_nxt = 4'h0;
          cmd_st_nxt   = irf_pkg::IRF_CMD_IDLE;
        end else if (cmd_done_in) begin
          cmd_code_nxt = 4'h0;
          idle_evt     = 1'b1;
          cmd_st_nxt   = irf_pkg::IRF_CMD_IDLE;
        end
      end
      irf_pkg::IRF_CMD_UNKNWN: begin
        cmd_code_nxt = 4'h0;
        idle_evt     = 1'b1;
        cmd_st_nxt   = irf_pkg::IRF_CMD_IDLE;
      end
      default: begin
        cmd_st_nxt = irf_pkg::IRF_CMD_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_sys_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      cmd_st_r   <= irf_pkg::IRF_CMD_IDLE;
      cmd_code_r <= 4'h0;
      com_en_r   <= `IRF_COM_EN_RST;
      misc_en_r  <= `IRF_MISC_EN_RST;
      rx_mode_r  <= `IRF_RXMODE_RST;
    end else if (clk_en_in) begin
      cmd_st_r   <= cmd_st_nxt;
      cmd_code_r <= cmd_code_nxt;
      com_en_r   <= com_en_nxt;
      misc_en_r  <= misc_en_nxt;
      rx_mode_r  <= rx_mode_nxt;
    end
  end

  // ----------------------------------------------------------------------
  // Edge detection
  // ----------------------------------------------------------------------
  logic [2:0] rise;
  logic [2:0] fall;

  irf_edge u_edge (
    .clk_sys_in (clk_sys_in),
    .sys_rst_in (sys_rst_in),
    .clk_en_in  (clk_en_in),
    .level_in   ({contactless_ext_input_in, fifo_high_status_in,
                  fifo_low_status_in}),
    .rise_out   (rise),
    .fall_out   (fall)
  );

  // ----------------------------------------------------------------------
  // Error flags
  // ----------------------------------------------------------------------
  logic [7:0] err_r;
  logic [7:0] err_nxt;
  logic [7:0] err_set;

  always_comb begin
    err_set = 8'h00;
    err_set[`IRF_ERR_WR] = fifo_host_wr_in &
                           (cmd_auth_active_in | rx_gap_active_in);
    err_set[`IRF_ERR_TEMP] = overheat_in;
    err_set[`IRF_ERR_OVFL] = fifo_full_in &
                             (fifo_host_wr_in | fifo_int_wr_in);
    err_set[`IRF_ERR_COLL] = bit_collision_in & rx_rate_106_in;
    err_set[`IRF_ERR_CRC]  = rx_checksum_bad_in &
                             rx_mode_r[`IRF_RXMODE_CRCEN];
    err_set[`IRF_ERR_PAR]  = parity_bad_in & rx_rate_106_in &
                             rx_type_a_in;
    err_set[`IRF_ERR_PROT] = (frame_start_bad_in & rx_rate_106_in) |
                             (auth_byte_count_bad_in &
                              cmd_auth_active_in);
    err_nxt = err_r;
    if (start_evt) begin
      err_nxt = err_r & `IRF_ERR_KEEP;
    end
    if (rx_start_in) begin
      err_nxt[`IRF_ERR_COLL] = 1'b0;
      err_nxt[`IRF_ERR_CRC]  = 1'b0;
      err_nxt[`IRF_ERR_PAR]  = 1'b0;
      err_nxt[`IRF_ERR_PROT] = 1'b0;
    end
    err_nxt = (err_nxt | err_set) & `IRF_ERR_MASK;
    if (!rx_rate_106_in) begin
      err_nxt[`IRF_ERR_COLL] = 1'b0;
    end
    err_nxt[`IRF_ERR_TEMP] = err_r[`IRF_ERR_TEMP] | overheat_in;
  end

  always_ff @(posedge clk_sys_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      err_r <= `IRF_ERR_RST;
    end else if (clk_en_in) begin
      err_r <= err_nxt;
    end
  end

  // ----------------------------------------------------------------------
  // Request registers
  // ----------------------------------------------------------------------
  logic [7:0] com_evt;
  logic [7:0] misc_evt;
  logic [7:0] com_flags;
  logic [7:0] misc_flags;

  always_comb begin
    com_evt = 8'h00;
    com_evt[`IRF_COM_TX]    = tx_last_bit_sent_in;
    com_evt[`IRF_COM_RX]    = rx_valid_end_in &
                              (~rx_mode_r[`IRF_RXMODE_NOERR] |
                               fifo_not_empty_in);
    com_evt[`IRF_COM_IDLE]  = idle_evt;
    com_evt[`IRF_COM_HI]    = rise[1];
    com_evt[`IRF_COM_LO]    = rise[0];
    com_evt[`IRF_COM_ERR]   = |err_r;
    com_evt[`IRF_COM_TIMER] = timer_zero_in;
    misc_evt = 8'h00;
    misc_evt[`IRF_MISC_EXT] = rise[2] | fall[2];
    misc_evt[`IRF_MISC_CRC] = cmd_calc_active_in &
                              calc_all_processed_in;
  end

  irf_setclr u_com_req (
    .clk_sys_in    (clk_sys_in),
    .sys_rst_in    (sys_rst_in),
    .clk_en_in     (clk_en_in),
    .reset_val_in  (`IRF_COM_RST),
    .valid_mask_in (`IRF_COM_MASK),
    .wr_in         (wr_com_req),
    .wdata_in      (reg_wdata_in),
    .event_in      (com_evt),
    .flags_out     (com_flags)
  );

  irf_setclr u_misc_req (
    .clk_sys_in    (clk_sys_in),
    .sys_rst_in    (sys_rst_in),
    .clk_en_in     (clk_en_in),
    .reset_val_in  (`IRF_MISC_RST),
    .valid_mask_in (`IRF_MISC_MASK),
    .wr_in         (wr_misc_req),
    .wdata_in      (reg_wdata_in),
    .event_in      (misc_evt),
    .flags_out     (misc_flags)
  );

  // ----------------------------------------------------------------------
  // Read port and outputs
  // ----------------------------------------------------------------------
  logic [7:0] rdata_r;
  logic [7:0] rdata_nxt;
  logic       irq_r;
  logic       irq_nxt;

  always_comb begin
    rdata_nxt = rdata_r;
    irq_nxt   = |(com_flags & com_en_r & `IRF_COM_MASK) |
                |(misc_flags & misc_en_r & `IRF_MISC_MASK);
    if (reg_rd_in) begin
      case (reg_addr_in)
        `IRF_OFF_COMMAND:  rdata_nxt = {4'h0, cmd_code_r};
        `IRF_OFF_COM_EN:   rdata_nxt = com_en_r;
        `IRF_OFF_MISC_EN:  rdata_nxt = misc_en_r;
        `IRF_OFF_COM_REQ:  rdata_nxt = com_flags & `IRF_COM_MASK;
        `IRF_OFF_MISC_REQ: rdata_nxt = misc_flags & `IRF_MISC_MASK;
        `IRF_OFF_ERR:      rdata_nxt = err_r;
        `IRF_OFF_RX_MODE:  rdata_nxt = rx_mode_r;
        default:           rdata_nxt = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clk_sys_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      rdata_r <= 8'h00;
      irq_r   <= 1'b0;
    end else if (clk_en_in) begin
      rdata_r <= rdata_nxt;
      irq_r   <= irq_nxt;
    end
  end

  assign reg_rdata_out    = rdata_r;
  assign command_code_out = cmd_code_r;
  assign cmd_start_out    = start_evt;
  assign antenna_off_out  = err_r[`IRF_ERR_TEMP];
  assign irq_summary_out  = irq_r;
  assign irq_pin_out      = irq_r ^ com_en_r[`IRF_EN_INV_BIT];
endmodule

// file: tb/irf_top_asserts.sv
// Concurrent checks on the ports of the request and error flag block.
`timescale 1ns/10ps
module irf_top_asserts (
  // Clock and reset
  input wire logic       clk_sys_in,
  input wire logic       sys_rst_in,
  input wire logic       clk_en_in,
  // Register port
  input wire logic [5:0] reg_addr_in,
  input wire logic [7:0] reg_wdata_in,
  input wire logic       reg_wr_in,
  input wire logic       reg_rd_in,
  input wire logic [7:0] reg_rdata_out,
  // Command and sensor
  input wire logic       overheat_in,
  input wire logic [3:0] command_code_out,
  input wire logic       cmd_start_out,
  input wire logic       antenna_off_out
);
  // ----------------------------------------
  // Helper terms
  // ----------------------------------------
  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (sys_rst_in);
  logic rd;
  logic wc;
  assign rd = reg_rd_in && clk_en_in;
  assign wc = reg_wr_in && clk_en_in && reg_addr_in == 6'h01
              && command_code_out == 4'h0;
  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  a_heat_drives_off: assert property (overheat_in && clk_en_in
    |-> ##[1:2] antenna_off_out) else $error("antenna drive not cut");
  a_antenna_off_sticks: assert property (antenna_off_out
    |=> antenna_off_out) else $error("antenna off dropped");
  a_antenna_from_heat: assert property ($rose(antenna_off_out)
    |-> $past(overheat_in)) else $error("antenna off without heat");
  a_rdata_holds: assert property (!rd
    |=> $stable(reg_rdata_out)) else $error("read data moved");
  a_unmapped_reads_zero: assert property (rd && !(reg_addr_in inside
    {6'h01, 6'h02, 6'h03, 6'h04, 6'h05, 6'h06, 6'h13})
    |=> reg_rdata_out == 8'h00) else $error("unmapped read not zero");
  a_com_select_zero: assert property (rd && reg_addr_in == 6'h04
    |=> !reg_rdata_out[7]) else $error("select bit read high");
  a_misc_reserved_zero: assert property (rd && reg_addr_in == 6'h05
    |=> (reg_rdata_out & 8'hEB) == 8'h00) else $error("reserved bit high");
  a_start_has_cause: assert property (cmd_start_out
    |-> reg_wr_in && reg_addr_in == 6'h01 && reg_wdata_in[3:0] != 4'h0
    && command_code_out == 4'h0) else $error("start without write");
  a_unknown_to_idle: assert property (wc && reg_wdata_in[3:0] == 4'h5
    |=> command_code_out == 4'h0) else $error("unknown code kept");
  a_known_cmd_loads: assert property (wc && reg_wdata_in[3:0] == 4'h1
    |=> command_code_out == 4'h1) else $error("command not loaded");
endmodule

bind irf_top irf_top_asserts u_chk (
  .clk_sys_in, .sys_rst_in, .clk_en_in, .reg_addr_in, .reg_wdata_in,
  .reg_wr_in, .reg_rd_in, .reg_rdata_out, .overheat_in,
  .command_code_out, .cmd_start_out, .antenna_off_out
);

// file: tb/tb_top.sv
// Register-level testbench of the request and error flag block.
`timescale 1ns/10ps
module tb_top;
  // ----------------------------------------
  // Signals
  // ----------------------------------------
  logic               clk_sys_in, sys_rst_in, clk_en_in;
  logic               reg_wr_in, reg_rd_in;
  logic [5:0]         reg_addr_in;
  irf_pkg::irf_byte_t reg_wdata_in, reg_rdata_out;
  logic [11:0]        ev, lv;
  logic [3:0]         command_code_out;
  logic               cmd_start_out, antenna_off_out;
  logic               irq_summary_out, irq_pin_out;
  int                 bad_count, checked;
  int                 ei[7] = '{1, 11, 2, 4, 5, 6, 7};
  irf_pkg::irf_byte_t ex[7] = '{8'h40, 8'h01, 8'h20, 8'h08, 8'h04,
                                8'h02, 8'h01};

  irf_top uut (
    .clk_sys_in, .sys_rst_in, .clk_en_in, .reg_addr_in, .reg_wdata_in,
    .reg_wr_in, .reg_rd_in, .reg_rdata_out,
    .cmd_done_in(ev[0]), .cmd_auth_active_in(lv[0]),
    .cmd_calc_active_in(lv[1]), .calc_all_processed_in(lv[2]),
    .tx_last_bit_sent_in(ev[1]), .rx_valid_end_in(ev[2]),
    .rx_start_in(ev[3]), .rx_gap_active_in(lv[3]),
    .rx_rate_106_in(lv[4]), .rx_type_a_in(lv[5]),
    .bit_collision_in(ev[4]), .rx_checksum_bad_in(ev[5]),
    .parity_bad_in(ev[6]), .frame_start_bad_in(ev[7]),
    .auth_byte_count_bad_in(ev[8]), .fifo_not_empty_in(lv[6]),
    .fifo_full_in(lv[7]), .fifo_host_wr_in(ev[9]),
    .fifo_int_wr_in(ev[10]), .fifo_high_status_in(lv[8]),
    .fifo_low_status_in(lv[9]), .timer_zero_in(ev[11]),
    .overheat_in(lv[10]), .contactless_ext_input_in(lv[11]),
    .command_code_out, .cmd_start_out, .antenna_off_out,
    .irq_summary_out, .irq_pin_out
  );

  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task automatic conclude();
    if (bad_count == 0 && checked > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  task automatic chk(string n, irf_pkg::irf_byte_t s, irf_pkg::irf_byte_t e);
    checked++;
    if (s !== e) begin
      bad_count++;
      $display("[FAIL] %s expected %h seen %h", n, e, s);
    end
  endtask

  task automatic step(int n);
    repeat (n) @(posedge clk_sys_in);
  endtask

  task automatic wr(logic [5:0] a, irf_pkg::irf_byte_t d);
    @(posedge clk_sys_in);
    reg_addr_in <= a;
    reg_wdata_in <= d;
    reg_wr_in <= 1'b1;
    @(posedge clk_sys_in);
    reg_wr_in <= 1'b0;
  endtask

  task automatic rchk(logic [5:0] a, irf_pkg::irf_byte_t e);
    @(posedge clk_sys_in);
    reg_addr_in <= a;
    reg_rd_in <= 1'b1;
    @(posedge clk_sys_in);
    reg_rd_in <= 1'b0;
    #1;
    chk($sformatf("register %h", a), reg_rdata_out, e);
  endtask

  task automatic pulse(int i);
    @(posedge clk_sys_in);
    ev <= 12'h001 << i;
    @(posedge clk_sys_in);
    ev <= 12'h000;
  endtask

  // ----------------------------------------
  // Clock, watchdog and sequence
  // ----------------------------------------
  initial begin
    clk_sys_in = 1'b0;
    forever #12.5 clk_sys_in = ~clk_sys_in;
  end

  initial begin
    repeat (20000) @(posedge clk_sys_in);
    bad_count++;
    conclude();
  end

  initial begin
    sys_rst_in = 1'b1;
    clk_en_in = 1'b1;
    reg_wr_in = 1'b0;
    reg_rd_in = 1'b0;
    reg_addr_in = 6'h00;
    reg_wdata_in = 8'h00;
    ev = 12'h000;
    lv = 12'h000;
    bad_count = 0;
    checked = 0;
    repeat (12) @(posedge clk_sys_in);
    sys_rst_in <= 1'b0;
    rchk(6'h04, 8'h14);
    rchk(6'h06, 8'h00);
    rchk(6'h05, 8'h00);
    rchk(6'h00, 8'h00);
    chk("irq pin", {7'h00, irq_pin_out}, 8'h01);
    wr(6'h04, 8'h14);
    rchk(6'h04, 8'h00);
    wr(6'h04, 8'h83);
    rchk(6'h04, 8'h03);
    wr(6'h04, 8'h02);
    rchk(6'h04, 8'h01);
    wr(6'h04, 8'hFF);
    rchk(6'h04, 8'h7F);
    wr(6'h04, 8'h7F);
    wr(6'h05, 8'hFF);
    rchk(6'h05, 8'h14);
    wr(6'h05, 8'h04);
    rchk(6'h05, 8'h10);
    wr(6'h05, 8'h10);
    rchk(6'h05, 8'h00);
    for (int k = 0; k < 3; k++) begin
      pulse(ei[k]);
      rchk(6'h04, ex[k]);
      wr(6'h04, ex[k]);
    end
    wr(6'h13, 8'h08);
    pulse(2);
    rchk(6'h04, 8'h00);
    lv[6] <= 1'b1;
    pulse(2);
    rchk(6'h04, 8'h20);
    wr(6'h04, 8'h20);
    lv[6] <= 1'b0;
    wr(6'h13, 8'h80);
    for (int k = 8; k < 10; k++) begin
      lv[k] <= 1'b1;
      step(3);
      lv[k] <= 1'b0;
      step(3);
      rchk(6'h04, 8'h08 >> (k - 8));
      wr(6'h04, 8'h08 >> (k - 8));
      rchk(6'h04, 8'h00);
    end
    lv[11] <= 1'b1;
    step(3);
    rchk(6'h05, 8'h10);
    wr(6'h05, 8'h10);
    lv[11] <= 1'b0;
    step(3);
    rchk(6'h05, 8'h10);
    wr(6'h05, 8'h10);
    lv[2:1] <= 2'b11;
    step(2);
    lv[2:1] <= 2'b00;
    rchk(6'h05, 8'h04);
    wr(6'h05, 8'h04);
    lv[5:4] <= 2'b11;
    for (int k = 3; k < 7; k++) begin
      pulse(ei[k]);
      rchk(6'h06, ex[k]);
      pulse(3);
      rchk(6'h06, 8'h00);
    end
    rchk(6'h04, 8'h02);
    wr(6'h04, 8'h02);
    lv[4] <= 1'b0;
    pulse(4);
    rchk(6'h06, 8'h00);
    lv[7] <= 1'b1;
    pulse(10);
    rchk(6'h06, 8'h10);
    lv[7] <= 1'b0;
    lv[0] <= 1'b1;
    pulse(9);
    rchk(6'h06, 8'h90);
    pulse(8);
    rchk(6'h06, 8'h91);
    wr(6'h06, 8'hFF);
    rchk(6'h06, 8'h91);
    lv[0] <= 1'b0;
    wr(6'h01, 8'h01);
    rchk(6'h06, 8'h00);
    wr(6'h04, 8'h7F);
    pulse(0);
    step(1);
    chk("command", {4'h0, command_code_out}, 8'h00);
    rchk(6'h04, 8'h10);
    wr(6'h04, 8'h10);
    wr(6'h01, 8'h01);
    wr(6'h01, 8'h00);
    rchk(6'h04, 8'h00);
    wr(6'h01, 8'h05);
    step(2);
    chk("command", {4'h0, command_code_out}, 8'h00);
    rchk(6'h04, 8'h10);
    wr(6'h04, 8'h10);
    wr(6'h02, 8'h01);
    step(2);
    chk("irq pin", {7'h00, irq_pin_out}, 8'h00);
    pulse(11);
    step(2);
    chk("summary", {7'h00, irq_summary_out}, 8'h01);
    chk("irq pin", {7'h00, irq_pin_out}, 8'h01);
    wr(6'h02, 8'h81);
    step(2);
    chk("irq pin", {7'h00, irq_pin_out}, 8'h00);
    wr(6'h04, 8'h01);
    step(2);
    chk("summary", {7'h00, irq_summary_out}, 8'h00);
    lv[10] <= 1'b1;
    step(3);
    lv[10] <= 1'b0;
    rchk(6'h06, 8'h40);
    chk("antenna", {7'h00, antenna_off_out}, 8'h01);
    wr(6'h01, 8'h01);
    rchk(6'h06, 8'h40);
    lv[3] <= 1'b1;
    pulse(9);
    rchk(6'h06, 8'hC0);
    lv[3] <= 1'b0;
    wr(6'h03, 8'h10);
    lv[11] <= 1'b1;
    step(3);
    chk("summary", {7'h00, irq_summary_out}, 8'h01);
    clk_en_in <= 1'b0;
    pulse(11);
    clk_en_in <= 1'b1;
    rchk(6'h04, 8'h02);
    conclude();
  end
endmodule
